// file: core/ipr_dev.sv
// I2C slave end: eight byte registers in four pairs behind a command pointer
`timescale 1ns/1ps
`include "ipr_defs.svh"
module ipr_dev (
    // Clock and power-on reset
    input wire logic clk,
    input wire logic resetn,
    // I2C wires
    ipr_if.dev bus,
    // Address select pins
    input wire logic [2:0] addr_pins,
    // Port pins
    input wire logic [15:0] port_in,
    output logic [15:0] port_out_q,
    output logic [15:0] port_dir_q,
    output logic [15:0] port_pol_q,
    // Interrupt, active low
    output logic int_n_q
);
    ipr_pkg::ipr_dev_state_t state_q;
    logic [3:0] bit_q;
    logic [7:0] sh_q;
    logic [2:0] ptr_q;
    logic rw_q;
    logic sda_oe_q;
    logic [7:0] wr_q [2:7];
    logic [15:0] snap_q;
    logic scl_s1_q;
    logic scl_s2_q;
    logic scl_s3_q;
    logic sda_s1_q;
    logic sda_s2_q;
    logic sda_s3_q;
    logic [2:0] addr_s1_q;
    logic [2:0] addr_s2_q;
    logic [15:0] port_s1_q;
    logic [15:0] port_s2_q;

    // Pair mate of a register index
    function automatic logic [2:0] pair_mate(input logic [2:0] idx);
        pair_mate = {idx[2:1], ~idx[0]};
    endfunction : pair_mate

    // True for the read-only input port pair
    function automatic logic is_input(input logic [2:0] idx);
        is_input = (idx[2:1] == `IPR_PAIR_IN);
    endfunction : is_input

    // Reset value of a writable register
    function automatic logic [7:0] rst_val(input logic [2:0] idx);
        case (idx[2:1])
            `IPR_PAIR_OUT: rst_val = `IPR_OUT_RST;
            `IPR_PAIR_POL: rst_val = `IPR_POL_RST;
            default: rst_val = `IPR_CFG_RST;
        endcase
    endfunction : rst_val

    // Synchronised edges and bus conditions
    wire scl_rise = scl_s2_q && !scl_s3_q;
    wire scl_fall = !scl_s2_q && scl_s3_q;
    wire start_det = scl_s2_q && scl_s3_q && sda_s3_q && !sda_s2_q;
    wire stop_det = scl_s2_q && scl_s3_q && !sda_s3_q && sda_s2_q;
    wire byte_done = scl_fall && (bit_q == `IPR_BYTE_BITS);
    wire addr_hit = (sh_q[7:1] == {`IPR_ADDR_HI, addr_s2_q});
    wire [15:0] in_val = port_s2_q ^ {wr_q[5], wr_q[4]};
    wire [7:0] in_byte = ptr_q[0] ? in_val[15:8] : in_val[7:0];
    wire [7:0] rd_byte = is_input(ptr_q) ? in_byte : wr_q[ptr_q];
    wire [15:0] int_hit = (in_val ^ snap_q) & {wr_q[7], wr_q[6]};

    assign bus.dev_sda_o = 1'b0;
    assign bus.dev_sda_oe = sda_oe_q;

    // Two flip-flops before any logic looks at outside levels
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            scl_s1_q <= 1'b1;
            scl_s2_q <= 1'b1;
            scl_s3_q <= 1'b1;
            sda_s1_q <= 1'b1;
            sda_s2_q <= 1'b1;
            sda_s3_q <= 1'b1;
            addr_s1_q <= 3'h0;
            addr_s2_q <= 3'h0;
            port_s1_q <= 16'h0000;
            port_s2_q <= 16'h0000;
        end else begin
            scl_s1_q <= bus.scl;
            scl_s2_q <= scl_s1_q;
            scl_s3_q <= scl_s2_q;
            sda_s1_q <= bus.sda;
            sda_s2_q <= sda_s1_q;
            sda_s3_q <= sda_s2_q;
            addr_s1_q <= addr_pins;
            addr_s2_q <= addr_s1_q;
            port_s1_q <= port_in;
            port_s2_q <= port_s1_q;
        end
    end

    // Register outputs, one cycle behind the register file
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            port_out_q <= {`IPR_OUT_RST, `IPR_OUT_RST};
            port_dir_q <= {`IPR_CFG_RST, `IPR_CFG_RST};
            port_pol_q <= {`IPR_POL_RST, `IPR_POL_RST};
            int_n_q <= 1'b1;
        end else begin
            port_out_q <= {wr_q[3], wr_q[2]};
            port_dir_q <= {wr_q[7], wr_q[6]};
            port_pol_q <= {wr_q[5], wr_q[4]};
            // Output-configured pins are masked and cannot interrupt
            int_n_q <= ~|int_hit;
        end
    end

    // Power-on reset is the only reset of this block
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state_q <= ipr_pkg::DEV_IDLE;
            bit_q <= 4'h0;
            sh_q <= 8'h00;
            ptr_q <= 3'h0;
            rw_q <= 1'b0;
            sda_oe_q <= 1'b0;
            snap_q <= 16'h0000;
            for (int i = 2; i < 8; i++) begin
                wr_q[i] <= rst_val(3'(i));
            end
        end else if (stop_det) begin
            state_q <= ipr_pkg::DEV_IDLE;
            sda_oe_q <= 1'b0;
        end else if (start_det) begin
            // Pointer is kept across a repeated start
            state_q <= ipr_pkg::DEV_ADDR;
            bit_q <= 4'h0;
            sda_oe_q <= 1'b0;
        end else begin
            case (state_q)
                ipr_pkg::DEV_ADDR, ipr_pkg::DEV_CMD, ipr_pkg::DEV_WDAT: begin
                    if (scl_rise) begin
                        sh_q <= {sh_q[6:0], sda_s2_q};
                        bit_q <= bit_q + 4'h1;
                    end else if (byte_done) begin
                        bit_q <= 4'h0;
                        sda_oe_q <= 1'b1;
                        if (state_q == ipr_pkg::DEV_ADDR) begin
                            // Foreign addresses are left alone
                            if (addr_hit) begin
                                rw_q <= sh_q[0];
                                state_q <= ipr_pkg::DEV_AACK;
                            end else begin
                                sda_oe_q <= 1'b0;
                                state_q <= ipr_pkg::DEV_IDLE;
                            end
                        end else if (state_q == ipr_pkg::DEV_CMD) begin
                            ptr_q <= sh_q[2:0];
                            state_q <= ipr_pkg::DEV_CACK;
                        end else begin
                            if (!is_input(ptr_q)) begin
                                wr_q[ptr_q] <= sh_q;
                            end
                            ptr_q <= pair_mate(ptr_q);
                            state_q <= ipr_pkg::DEV_WACK;
                        end
                    end
                end
                ipr_pkg::DEV_AACK: begin
                    if (scl_fall) begin
                        if (rw_q) begin
                            // Transmit byte is sampled at the acknowledge fall
                            sh_q <= rd_byte;
                            sda_oe_q <= !rd_byte[7];
                            state_q <= ipr_pkg::DEV_RDAT;
                        end else begin
                            sda_oe_q <= 1'b0;
                            state_q <= ipr_pkg::DEV_CMD;
                        end
                    end
                end
                ipr_pkg::DEV_CACK, ipr_pkg::DEV_WACK: begin
                    if (scl_fall) begin
                        sda_oe_q <= 1'b0;
                        state_q <= ipr_pkg::DEV_WDAT;
                    end
                end
                ipr_pkg::DEV_RDAT: begin
                    // Rotation leaves the sent byte in place after eight falls
                    if (scl_fall) begin
                        sh_q <= {sh_q[6:0], sh_q[7]};
                        bit_q <= bit_q + 4'h1;
                        if (bit_q == 4'h7) begin
                            sda_oe_q <= 1'b0;
                            state_q <= ipr_pkg::DEV_MACK;
                        end else begin
                            sda_oe_q <= !sh_q[6];
                        end
                    end
                end
                ipr_pkg::DEV_MACK: begin
                    if (scl_rise) begin
                        ptr_q <= pair_mate(ptr_q);
                        if (is_input(ptr_q)) begin
                            // Snapshot takes the sent byte, so changes arising in this pulse still interrupt
                            if (ptr_q[0]) begin
                                snap_q[15:8] <= sh_q;
                            end else begin
                                snap_q[7:0] <= sh_q;
                            end
                        end
                        if (sda_s2_q) begin
                            state_q <= ipr_pkg::DEV_IDLE;
                        end
                    end else if (scl_fall) begin
                        sh_q <= rd_byte;
                        sda_oe_q <= !rd_byte[7];
                        bit_q <= 4'h0;
                        state_q <= ipr_pkg::DEV_RDAT;
                    end
                end
                ipr_pkg::DEV_IDLE: begin
                    sda_oe_q <= 1'b0;
                end
                default: begin
                    state_q <= ipr_pkg::DEV_IDLE;
                    sda_oe_q <= 1'b0;
                end
            endcase
        end
    end
endmodule : ipr_dev

// file: shared/ipr_defs.svh
// Constants of the I2C port-register pair block
`ifndef IPR_DEFS_SVH
`define IPR_DEFS_SVH

// Fixed upper four address bits, lower three from the address pins
`define IPR_ADDR_HI 4'h4
// Reset values of the writable register pairs
`define IPR_OUT_RST 8'hFF
`define IPR_POL_RST 8'h00
`define IPR_CFG_RST 8'hFF
// Pair index of the read-only input ports
`define IPR_PAIR_IN 2'h0
`define IPR_PAIR_OUT 2'h1
`define IPR_PAIR_POL 2'h2
`define IPR_PAIR_CFG 2'h3
// Bits in a byte, counting the bit clocks of one byte
`define IPR_BYTE_BITS 4'h8
// Serial clock timing of the master
`define IPR_CLK_NS 10
`define IPR_SCL_NS 2500
`define IPR_QTR_CYC ((`IPR_SCL_NS + 4 * `IPR_CLK_NS - 1) / (4 * `IPR_CLK_NS))

`endif

// file: shared/ipr_pkg.sv
// Types shared by both ends of the I2C port-register pair link
package ipr_pkg;

    typedef enum logic [8:0] {
        DEV_IDLE = 9'h001,
        DEV_ADDR = 9'h002,
        DEV_AACK = 9'h004,
        DEV_CMD = 9'h008,
        DEV_CACK = 9'h010,
        DEV_WDAT = 9'h020,
        DEV_WACK = 9'h040,
        DEV_RDAT = 9'h080,
        DEV_MACK = 9'h100
    } ipr_dev_state_t;

    typedef enum logic [3:0] {
        HST_IDLE = 4'h1,
        HST_START = 4'h2,
        HST_BIT = 4'h4,
        HST_STOP = 4'h8
    } ipr_hst_state_t;

endpackage : ipr_pkg

// file: shared/ipr_if.sv
// Open-drain I2C wires joining the master end and the device end
`timescale 1ns/1ps
interface ipr_if;
    logic host_scl_o;
    logic host_scl_oe;
    logic host_sda_o;
    logic host_sda_oe;
    logic dev_sda_o;
    logic dev_sda_oe;
    logic scl;
    logic sda;

    // Wired-AND with pull-up: released lines read high
    assign scl = host_scl_oe ? host_scl_o : 1'b1;
    assign sda = (host_sda_oe ? host_sda_o : 1'b1) & (dev_sda_oe ? dev_sda_o : 1'b1);

    modport host (
        output host_scl_o,
        output host_scl_oe,
        output host_sda_o,
        output host_sda_oe,
        input sda
    );

    modport dev (
        input scl,
        input sda,
        output dev_sda_o,
        output dev_sda_oe
    );
endinterface : ipr_if

// file: core/ipr_host.sv
// I2C master end: writes or reads one register pair per request
`timescale 1ns/1ps
`include "ipr_defs.svh"
module ipr_host (
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // I2C wires
    ipr_if.host bus,
    // Request
    input wire logic req,
    input wire logic req_read,
    input wire logic [6:0] req_addr,
    input wire logic [7:0] req_cmd,
    input wire logic [15:0] req_wdata,
    // Answer
    output logic busy_q,
    output logic done_q,
    output logic nack_q,
    output logic [15:0] rdata_q
);
    localparam logic [6:0] QTR_LAST = 7'(`IPR_QTR_CYC - 1);

    ipr_pkg::ipr_hst_state_t state_q;
    logic [6:0] qcnt_q;
    logic [1:0] phase_q;
    logic [2:0] step_q;
    logic [3:0] bit_q;
    logic [7:0] sh_q;
    logic read_q;
    logic [6:0] addr_q;
    logic [7:0] cmd_q;
    logic [15:0] wdata_q;
    logic scl_oe_q;
    logic sda_oe_q;
    logic sda_s1_q;
    logic sda_s2_q;

    wire tick = (qcnt_q == QTR_LAST);
    wire rx_byte = read_q && (step_q >= 3'h3);
    wire last_step = (step_q == (read_q ? 3'h4 : 3'h3));
    wire byte_bit = (bit_q < `IPR_BYTE_BITS);
    // Step 2 of a read is the address again with the read direction
    wire [7:0] tx_byte = (step_q == 3'h0) ? {addr_q, 1'b0} :
                         (step_q == 3'h1) ? cmd_q :
                         (step_q == 3'h2) ? (read_q ? {addr_q, 1'b1} : wdata_q[7:0]) :
                         wdata_q[15:8];

    assign bus.host_scl_o = 1'b0;
    assign bus.host_sda_o = 1'b0;
    assign bus.host_scl_oe = scl_oe_q;
    assign bus.host_sda_oe = sda_oe_q;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            sda_s1_q <= 1'b1;
            sda_s2_q <= 1'b1;
        end else begin
            sda_s1_q <= bus.sda;
            sda_s2_q <= sda_s1_q;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state_q <= ipr_pkg::HST_IDLE;
            qcnt_q <= 7'h00;
            phase_q <= 2'h0;
            step_q <= 3'h0;
            bit_q <= 4'h0;
            sh_q <= 8'h00;
            read_q <= 1'b0;
            addr_q <= 7'h00;
            cmd_q <= 8'h00;
            wdata_q <= 16'h0000;
            scl_oe_q <= 1'b0;
            sda_oe_q <= 1'b0;
            busy_q <= 1'b0;
            done_q <= 1'b0;
            nack_q <= 1'b0;
            rdata_q <= 16'h0000;
        end else begin
            done_q <= 1'b0;
            qcnt_q <= (tick || state_q == ipr_pkg::HST_IDLE) ? 7'h00 : qcnt_q + 7'h01;
            if (tick) begin
                phase_q <= phase_q + 2'h1;
            end
            case (state_q)
                ipr_pkg::HST_IDLE: begin
                    // Only start on an idle bus
                    if (req && sda_s2_q) begin
                        state_q <= ipr_pkg::HST_START;
                        phase_q <= 2'h0;
                        step_q <= 3'h0;
                        read_q <= req_read;
                        addr_q <= req_addr;
                        cmd_q <= req_cmd;
                        wdata_q <= req_wdata;
                        busy_q <= 1'b1;
                        nack_q <= 1'b0;
                    end
                end
                ipr_pkg::HST_START: begin
                    // Also serves as repeated start from a low clock
                    if (tick) begin
                        case (phase_q)
                            2'h0: sda_oe_q <= 1'b0;
                            2'h1: scl_oe_q <= 1'b0;
                            2'h2: sda_oe_q <= 1'b1;
                            default: begin
                                scl_oe_q <= 1'b1;
                                bit_q <= 4'h0;
                                state_q <= ipr_pkg::HST_BIT;
                            end
                        endcase
                    end
                end
                ipr_pkg::HST_BIT: begin
                    if (tick) begin
                        case (phase_q)
                            2'h0: begin
                                if (bit_q == 4'h0) begin
                                    sh_q <= tx_byte;
                                    sda_oe_q <= !rx_byte && !tx_byte[7];
                                end else if (byte_bit) begin
                                    sda_oe_q <= !rx_byte && !sh_q[7];
                                end else begin
                                    // Last read byte is not acknowledged
                                    sda_oe_q <= rx_byte && !last_step;
                                end
                            end
                            2'h1: scl_oe_q <= 1'b0;
                            2'h2: begin
                                if (byte_bit) begin
                                    sh_q <= {sh_q[6:0], sda_s2_q};
                                end else if (!rx_byte && sda_s2_q) begin
                                    nack_q <= 1'b1;
                                end
                            end
                            default: begin
                                scl_oe_q <= 1'b1;
                                bit_q <= bit_q + 4'h1;
                                if (!byte_bit) begin
                                    bit_q <= 4'h0;
                                    step_q <= step_q + 3'h1;
                                    if (step_q == 3'h3 && read_q) begin
                                        rdata_q[7:0] <= sh_q;
                                    end
                                    if (step_q == 3'h4) begin
                                        rdata_q[15:8] <= sh_q;
                                    end
                                    if (last_step || nack_q) begin
                                        state_q <= ipr_pkg::HST_STOP;
                                    end else if (read_q && step_q == 3'h1) begin
                                        state_q <= ipr_pkg::HST_START;
                                    end
                                end
                            end
                        endcase
                    end
                end
                ipr_pkg::HST_STOP: begin
                    if (tick) begin
                        case (phase_q)
                            2'h0: sda_oe_q <= 1'b1;
                            2'h1: scl_oe_q <= 1'b0;
                            2'h2: sda_oe_q <= 1'b0;
                            default: begin
                                state_q <= ipr_pkg::HST_IDLE;
                                busy_q <= 1'b0;
                                done_q <= 1'b1;
                            end
                        endcase
                    end
                end
                default: state_q <= ipr_pkg::HST_IDLE;
            endcase
        end
    end
endmodule : ipr_host

// file: test/ipr_props.sv
// Concurrent checks on the I2C wires between the master end and the device end
`timescale 1ns/1ps
`include "ipr_defs.svh"
module ipr_props #(
    parameter logic [2:0] PINS = 3'h0
) (
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // Interface wires
    input wire logic host_scl_o,
    input wire logic host_scl_oe,
    input wire logic host_sda_o,
    input wire logic host_sda_oe,
    input wire logic dev_sda_o,
    input wire logic dev_sda_oe,
    input wire logic scl,
    input wire logic sda
);
    logic scl_p_q;
    logic sda_p_q;
    logic [5:0] cnt_q;
    logic [7:0] sh_q;
    logic rd_q;
    logic wr_q;
    logic frame_q;
    wire scl_rise = scl && !scl_p_q;
    wire start_ev = scl && scl_p_q && sda_p_q && !sda;
    wire stop_ev = scl && scl_p_q && !sda_p_q && sda;
    wire addr_hit = sh_q[7:1] == {`IPR_ADDR_HI, PINS};
    wire bit9 = scl_rise && cnt_q == 6'h08;

    // Bits counted from each START, so a repeated start restarts the byte frame
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            scl_p_q <= 1'b1;
            sda_p_q <= 1'b1;
            cnt_q <= 6'h00;
            sh_q <= 8'h00;
            rd_q <= 1'b0;
            wr_q <= 1'b0;
            frame_q <= 1'b0;
        end else begin
            scl_p_q <= scl;
            sda_p_q <= sda;
            // Bus counts as busy from a START until the next STOP
            if (start_ev) begin
                frame_q <= 1'b1;
            end else if (stop_ev) begin
                frame_q <= 1'b0;
            end
            if (start_ev) begin
                cnt_q <= 6'h00;
                rd_q <= 1'b0;
                wr_q <= 1'b0;
            end else if (scl_rise) begin
                cnt_q <= cnt_q + 6'h01;
                sh_q <= {sh_q[6:0], sda};
                rd_q <= (cnt_q == 6'h08) ? (addr_hit && sh_q[0]) : rd_q;
                wr_q <= (cnt_q == 6'h08) ? (addr_hit && !sh_q[0]) : wr_q;
            end
        end
    end

    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);

    frame_clk_a: assert property ($rose(host_scl_oe) |-> frame_q)
        else $error("clock pulled low outside a frame");
    reset_lines_a: assert property (disable iff (1'b0) !resetn |-> !host_scl_oe && !host_sda_oe && !dev_sda_oe)
        else $error("line driven in reset");
    start_idle_a: assert property (start_ev |-> !dev_sda_oe)
        else $error("start while device drives");
    dev_stable_a: assert property ($changed(dev_sda_oe) |-> !scl)
        else $error("device data moved with clock high");
    addr_ack_a: assert property (bit9 |-> sda == !addr_hit)
        else $error("address acknowledge wrong");
    byte_ack_a: assert property (scl_rise && wr_q && (cnt_q == 6'h11 || cnt_q == 6'h1A || cnt_q == 6'h23) |-> !sda)
        else $error("written byte not acknowledged");
    rd_quiet_a: assert property (scl_rise && rd_q && cnt_q >= 6'h09 && cnt_q <= 6'h10 |-> !host_sda_oe)
        else $error("master drives during read data");
    rd_release_a: assert property (scl_rise && rd_q && (cnt_q == 6'h11 || cnt_q == 6'h1A) |-> !dev_sda_oe)
        else $error("device holds line at master acknowledge");
    stop_idle_a: assert property (stop_ev |=> !dev_sda_oe [*8])
        else $error("device drives after stop");

    cover property (bit9 && !addr_hit);
    cover property (scl_rise && rd_q && cnt_q == 6'h1A);
    cover property (scl_rise && wr_q && cnt_q == 6'h23);
endmodule : ipr_props

// file: test/test_i2c_port_register_pair_access.sv
// Bench: master end writes and reads the register pairs of the device end
`timescale 1ns/1ps
module test_i2c_port_register_pair_access;
    logic clk;
    logic resetn;
    logic req;
    logic req_read;
    logic [6:0] req_addr;
    logic [7:0] req_cmd;
    logic [15:0] req_wdata;
    logic busy_q;
    logic done_q;
    logic nack_q;
    logic [15:0] rdata_q;
    logic [2:0] addr_pins;
    logic [15:0] port_in;
    logic [15:0] port_out_q;
    logic [15:0] port_dir_q;
    logic [15:0] port_pol_q;
    logic int_n_q;
    int err_count = 0;
    int check_count = 0;
    int cyc_count = 0;

    ipr_if bus_if();
    ipr_host u_ipr_host (.clk(clk), .resetn(resetn), .bus(bus_if), .req(req), .req_read(req_read),
        .req_addr(req_addr), .req_cmd(req_cmd), .req_wdata(req_wdata), .busy_q(busy_q), .done_q(done_q),
        .nack_q(nack_q), .rdata_q(rdata_q));
    ipr_dev u_ipr_dev (.clk(clk), .resetn(resetn), .bus(bus_if), .addr_pins(addr_pins), .port_in(port_in),
        .port_out_q(port_out_q), .port_dir_q(port_dir_q), .port_pol_q(port_pol_q), .int_n_q(int_n_q));
    ipr_props #(.PINS(3'h0)) u_ipr_props (.clk(clk), .resetn(resetn), .host_scl_o(bus_if.host_scl_o),
        .host_scl_oe(bus_if.host_scl_oe), .host_sda_o(bus_if.host_sda_o), .host_sda_oe(bus_if.host_sda_oe),
        .dev_sda_o(bus_if.dev_sda_o), .dev_sda_oe(bus_if.dev_sda_oe), .scl(bus_if.scl), .sda(bus_if.sda));

    task automatic end_sim;
        if (err_count == 0 && check_count > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : end_sim

    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_count++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    // Request held until the master shows busy, then completion awaited under a bound
    task automatic xfer(input logic rd, input logic [6:0] addr, input logic [7:0] cmd, input logic [15:0] wdata);
        int n;
        @(negedge clk);
        req = 1'b1;
        req_read = rd;
        req_addr = addr;
        req_cmd = cmd;
        req_wdata = wdata;
        n = 0;
        while (busy_q !== 1'b1 && n < 20) begin
            @(negedge clk);
            n++;
        end
        check("busy", {15'h0000, busy_q}, 16'h0001);
        req = 1'b0;
        n = 0;
        while (done_q !== 1'b1 && n < 16000) begin
            @(negedge clk);
            n++;
        end
        check("done", {15'h0000, done_q}, 16'h0001);
        check("busy", {15'h0000, busy_q}, 16'h0000);
    endtask : xfer

    task automatic write_pair(input logic [6:0] addr, input logic [7:0] cmd, input logic [15:0] wdata);
        xfer(1'b0, addr, cmd, wdata);
    endtask : write_pair

    task automatic read_pair(input logic [6:0] addr, input logic [7:0] cmd, output logic [15:0] rdata);
        xfer(1'b1, addr, cmd, 16'h0000);
        rdata = rdata_q;
    endtask : read_pair

    task automatic do_reset;
        @(negedge clk);
        resetn = 1'b0;
        repeat (10) @(negedge clk);
        resetn = 1'b1;
        @(negedge clk);
        check("out", port_out_q, 16'hFFFF);
        check("dir", port_dir_q, 16'hFFFF);
        check("pol", port_pol_q, 16'h0000);
    endtask : do_reset

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // Cuts a hang short; the planned run uses close to three quarters of this limit
    always @(posedge clk) begin
        cyc_count++;
        if (cyc_count == 90000) begin
            err_count++;
            end_sim();
        end
    end

    initial begin
        logic [15:0] rd;
        resetn = 1'b0;
        req = 1'b0;
        req_read = 1'b0;
        req_addr = 7'h20;
        req_cmd = 8'h00;
        req_wdata = 16'h0000;
        addr_pins = 3'h0;
        port_in = 16'h0000;
        do_reset();
        check("int", {15'h0000, int_n_q}, 16'h0001);
        write_pair(7'h20, 8'h03, 16'hA53C);
        check("out", port_out_q, 16'h3CA5);
        check("nack", {15'h0000, nack_q}, 16'h0000);
        write_pair(7'h20, 8'h04, 16'h5A0F);
        check("pol", port_pol_q, 16'h5A0F);
        write_pair(7'h20, 8'h06, 16'hFF0F);
        check("dir", port_dir_q, 16'hFF0F);
        write_pair(7'h20, 8'h00, 16'hBEEF);
        check("nack", {15'h0000, nack_q}, 16'h0000);
        check("out", port_out_q, 16'h3CA5);
        check("pol", port_pol_q, 16'h5A0F);
        port_in = 16'h1234;
        repeat (10) @(negedge clk);
        check("int", {15'h0000, int_n_q}, 16'h0000);
        read_pair(7'h20, 8'h01, rd);
        check("rdata", rd, 16'h3B48);
        check("int", {15'h0000, int_n_q}, 16'h0001);
        read_pair(7'h20, 8'h02, rd);
        check("rdata", rd, 16'h3CA5);
        write_pair(7'h27, 8'h03, 16'h0000);
        check("nack", {15'h0000, nack_q}, 16'h0001);
        check("out", port_out_q, 16'h3CA5);
        do_reset();
        end_sim();
    end
endmodule : test_i2c_port_register_pair_access
